// ==== src/sse_pkg.sv ====
/*
  Shared constants, types and decode functions for the sleep-slot and
  external-enable control block.
  Assumes a single 50 MHz clock and 16-bit register words.
*/
`default_nettype none
package sse_pkg;
  // Register addresses on the plain register port.
  localparam logic [15:0] REG11_SLEEP_ADDR = 16'h4088;
  localparam logic [15:0] EXT_EN1_ADDR     = 16'h4089;
  localparam logic [15:0] CTRL_ADDR        = 16'h40f0;
  localparam logic [15:0] STATUS_ADDR      = 16'h40f1;

  // Field positions.
  localparam int SLOT_MSB   = 15;
  localparam int SLOT_LSB   = 13;
  localparam int HWSRC_MSB  = 12;
  localparam int HWSRC_LSB  = 11;
  localparam int HWCEN_BIT  = 8;
  localparam int XSLP_MSB   = 7;
  localparam int XSLP_LSB   = 5;
  localparam int VSEL_MSB   = 3;
  localparam int VSEL_LSB   = 0;
  localparam int SOFTEN_BIT = 0;
  localparam int HWASGN_BIT = 1;

  // Reset values and writable-bit masks.
  localparam logic [15:0] REG11_RST  = 16'h0000;
  localparam logic [15:0] EXT_RST    = 16'h0000;
  localparam logic [15:0] REG11_MASK = 16'he00f;
  localparam logic [15:0] EXT_MASK   = 16'hf9e0;

  // Selector codes for hardware-enable following, and the last timeslot.
  localparam logic [2:0] FOLLOW_EN1 = 3'h6;
  localparam logic [2:0] FOLLOW_EN2 = 3'h7;
  localparam logic [2:0] LAST_SLOT  = 3'h5;

  // Sleep voltage scale in millivolts.
  localparam logic [10:0] VOLT_BASE_MV = 11'h320;
  localparam logic [10:0] VOLT_STEP_MV = 11'h032;

  // Timeslot interval.
  localparam int CLK_PERIOD_NS = 20;
  localparam int SLOT_TIME_NS  = 2000000;
  localparam int SLOT_CYCLES   = SLOT_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_RUN  = 1'b1
  } sse_seq_state_type;

  // Slot in which a sleep code disables or sleeps; 0 means none.
  function automatic logic [2:0] sleepSlot(input logic [2:0] code);
    case (code)
      3'h1: sleepSlot = 3'h5;
      3'h2: sleepSlot = 3'h4;
      3'h3: sleepSlot = 3'h3;
      3'h4: sleepSlot = 3'h2;
      3'h5: sleepSlot = 3'h1;
      default: sleepSlot = 3'h0;
    endcase
  endfunction

  // Slot of the regulator voltage and mode transition; 0 means none.
  function automatic logic [2:0] transSlot(input logic [2:0] code);
    case (code)
      3'h0: transSlot = 3'h5;
      3'h6: transSlot = 3'h3;
      3'h7: transSlot = 3'h1;
      default: transSlot = 3'h0;
    endcase
  endfunction

  // Slot in which the ON sequence asserts the enable; 0 means none.
  function automatic logic [2:0] onSlot(input logic [2:0] code);
    onSlot = (code <= LAST_SLOT) ? code : 3'h0;
  endfunction

  // Linear sleep voltage in millivolts.
  function automatic logic [10:0] voltMv(input logic [3:0] code);
    voltMv = 11'(VOLT_BASE_MV + 11'(code) * VOLT_STEP_MV);
  endfunction
endpackage
`default_nettype wire

// ==== src/sse_sync.sv ====
/*
  Two-flop synchroniser for a group of independent level inputs.
  Assumes each bit is a slow level; bits are not coherent with each other.
*/
`timescale 1ns/100ps
`default_nettype none
module sse_sync #(
  parameter int W = 4
) (
  input  wire logic         clk,    // System clock.
  input  wire logic         rst,    // Synchronous reset, active high.
  input  wire logic [W-1:0] async,  // Asynchronous levels.
  output logic      [W-1:0] synced  // Levels after two flops.
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  // The first flop feeds only the second.
  always_comb begin
    meta_nxt = async;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign synced = sync_r;
endmodule
`default_nettype wire

// ==== src/sse_slot_seq.sv ====
/*
  Timeslot stepper: walks slots 1 to 5 at a fixed interval after a start.
  Assumes start pulses come from logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module sse_slot_seq #(
  parameter int SLOT_CYCLES = sse_pkg::SLOT_CYCLES
) (
  input  wire logic       clk,        // System clock.
  input  wire logic       rst,        // Synchronous reset, active high.
  input  wire logic       startOn,    // Start an ON walk, one-cycle pulse.
  input  wire logic       startSleep, // Start a SLEEP walk, one-cycle pulse.
  output logic      [2:0] slot,       // Current slot, 0 when idle.
  output logic            slotPulse,  // One cycle at entry to each slot.
  output logic            sleepPhase, // High while the walk is a SLEEP one.
  output logic            busy        // High while a walk runs.
);
  localparam int CW = $clog2(SLOT_CYCLES + 1);

  sse_pkg::sse_seq_state_type state_r, state_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [2:0]    slot_r, slot_nxt;
  logic          pulse_r, pulse_nxt;
  logic          phase_r, phase_nxt;

  // Starts during a walk are ignored so slots never skip or repeat.
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    slot_nxt  = slot_r;
    pulse_nxt = 1'b0;
    phase_nxt = phase_r;
    case (state_r)
      sse_pkg::SEQ_IDLE: begin
        if (startOn || startSleep) begin
          state_nxt = sse_pkg::SEQ_RUN;
          cnt_nxt   = '0;
          slot_nxt  = 3'h1;
          pulse_nxt = 1'b1;
          phase_nxt = startSleep && !startOn;
        end
      end
      sse_pkg::SEQ_RUN: begin
        if (cnt_r == CW'(SLOT_CYCLES - 1)) begin
          cnt_nxt = '0;
          if (slot_r == sse_pkg::LAST_SLOT) begin
            state_nxt = sse_pkg::SEQ_IDLE;
            slot_nxt  = 3'h0;
          end else begin
            slot_nxt  = slot_r + 3'h1;
            pulse_nxt = 1'b1;
          end
        end else begin
          cnt_nxt = cnt_r + CW'(1);
        end
      end
      default: state_nxt = sse_pkg::SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= sse_pkg::SEQ_IDLE;
      cnt_r   <= '0;
      slot_r  <= 3'h0;
      pulse_r <= 1'b0;
      phase_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      slot_r  <= slot_nxt;
      pulse_r <= pulse_nxt;
      phase_r <= phase_nxt;
    end
  end

  assign slot       = slot_r;
  assign slotPulse  = pulse_r;
  assign sleepPhase = phase_r;
  assign busy       = (state_r == sse_pkg::SEQ_RUN);

  // Slots only ever step up by one.
  slot_step_a: assert property (@(posedge clk) disable iff (rst)
    (slot_r != $past(slot_r)) && (slot_r != 3'h0) |->
      (slot_r == $past(slot_r) + 3'h1))
    else $error("Timeslot did not step by one.");
endmodule
`default_nettype wire

// ==== src/sse_ctrl.sv ====
/*
  Sleep-slot control for regulator 11 and the external power enable 1 output,
  with its register port and timeslot stepper.
  Assumes the power state machine pulses onStart and sleepStart on this clock,
  and the hardware enable and control pins are asynchronous levels.
*/
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Regulator sleep slot codes 000, 110 and 111 make the sleep transition in slots 5, 3 and 1.
// - Regulator sleep slot codes 001 to 101 disable the regulator in slots 5 down to 1.
// - With the regulator on a hardware enable, codes 001 to 101 put it to sleep instead.
// - The sleep voltage code gives 800 mV plus 50 mV per step.
// - ON slot codes 110 and 111 make the output follow hardware enable 1 or 2.
// - The source field picks none, input 1, input 2 or either input as hardware control.
// - With hardware control off and ON slot codes below 110, the output follows the software enable alone.
// - With hardware control on and ON slot codes below 110, an active chosen input forces the output low.
// - The enable sleep slot codes 001 to 101 deassert it in slots 5 down to 1; others do nothing.
module sse_ctrl #(
  parameter int SLOT_CYCLES = sse_pkg::SLOT_CYCLES
) (
  input  wire logic        clk,             // System clock, 50 MHz.
  input  wire logic        rst,             // Synchronous reset, active high.
  input  wire logic [15:0] addr,            // Register address.
  input  wire logic [15:0] wdata,           // Write data.
  input  wire logic        wr,              // Write strobe.
  input  wire logic        rd,              // Read strobe.
  output logic      [15:0] rdata,           // Read data, cycle after rd.
  input  wire logic        onStart,         // Begin ON walk, pulse.
  input  wire logic        sleepStart,      // Begin SLEEP walk, pulse.
  input  wire logic        hwEnable1,       // Hardware enable pin 1.
  input  wire logic        hwEnable2,       // Hardware enable pin 2.
  input  wire logic        hwControl1,      // Hardware control pin 1.
  input  wire logic        hwControl2,      // Hardware control pin 2.
  output logic             extPowerEn1,     // External power enable 1.
  output logic             reg11Enable,     // Regulator 11 enabled.
  output logic             reg11Sleep,      // Regulator 11 in sleep setting.
  output logic      [10:0] reg11SleepMv     // Sleep voltage in millivolts.
);
  logic [3:0]  pinSync;
  logic [2:0]  slot;
  logic        slotPulse;
  logic        sleepPhase;
  logic        busy;

  logic [15:0] reg11Cfg_r, reg11Cfg_nxt;
  logic [15:0] extCfg_r, extCfg_nxt;
  logic        softEn_r, softEn_nxt;
  logic        hwAssign_r, hwAssign_nxt;
  logic        extOut_r, extOut_nxt;
  logic        regEn_r, regEn_nxt;
  logic        regSlp_r, regSlp_nxt;
  logic [10:0] mv_r, mv_nxt;
  logic [15:0] rdata_r, rdata_nxt;

  logic [2:0]  regCode;
  logic [2:0]  onCode;
  logic [2:0]  xSlpCode;
  logic [1:0]  hwSrc;
  logic        hwcEn;
  logic        hwcActive;
  logic        onHit;
  logic        xSlpHit;
  logic        regDisHit;
  logic        regTransHit;
  logic        walkStart;

  // Pin levels cross into the clock domain before any decode.
  sse_sync #(
    .W (4)
  ) u_sync (
    .clk    (clk),
    .rst    (rst),
    .async  ({hwControl2, hwControl1, hwEnable2, hwEnable1}),
    .synced (pinSync)
  );

  // Walk stepper; every slot action below keys off its entry pulse.
  sse_slot_seq #(
    .SLOT_CYCLES (SLOT_CYCLES)
  ) u_seq (
    .clk        (clk),
    .rst        (rst),
    .startOn    (onStart),
    .startSleep (sleepStart),
    .slot       (slot),
    .slotPulse  (slotPulse),
    .sleepPhase (sleepPhase),
    .busy       (busy)
  );

  // Field decode and slot matches.
  assign regCode   = reg11Cfg_r[sse_pkg::SLOT_MSB:sse_pkg::SLOT_LSB];
  assign onCode    = extCfg_r[sse_pkg::SLOT_MSB:sse_pkg::SLOT_LSB];
  assign xSlpCode  = extCfg_r[sse_pkg::XSLP_MSB:sse_pkg::XSLP_LSB];
  assign hwSrc     = extCfg_r[sse_pkg::HWSRC_MSB:sse_pkg::HWSRC_LSB];
  assign hwcEn     = extCfg_r[sse_pkg::HWCEN_BIT];
  assign hwcActive = (hwSrc[0] && pinSync[2]) || (hwSrc[1] && pinSync[3]);
  assign onHit     = slotPulse && !sleepPhase && (sse_pkg::onSlot(onCode) == slot)
                     && (slot != 3'h0);
  assign xSlpHit   = slotPulse && sleepPhase && (sse_pkg::sleepSlot(xSlpCode) == slot);
  assign regDisHit = slotPulse && sleepPhase && (sse_pkg::sleepSlot(regCode) == slot);
  assign regTransHit = slotPulse && sleepPhase && (sse_pkg::transSlot(regCode) == slot);
  assign walkStart = onStart && !busy;

  // Register writes; slot actions win over a software write in the same cycle.
  // Software therefore cannot cancel a slot action by writing the enable in that cycle.
  always_comb begin
    reg11Cfg_nxt = reg11Cfg_r;
    extCfg_nxt   = extCfg_r;
    softEn_nxt   = softEn_r;
    hwAssign_nxt = hwAssign_r;
    if (wr) begin
      case (addr)
        sse_pkg::REG11_SLEEP_ADDR: reg11Cfg_nxt = wdata & sse_pkg::REG11_MASK;
        sse_pkg::EXT_EN1_ADDR:     extCfg_nxt = wdata & sse_pkg::EXT_MASK;
        sse_pkg::CTRL_ADDR: begin
          softEn_nxt   = wdata[sse_pkg::SOFTEN_BIT];
          hwAssign_nxt = wdata[sse_pkg::HWASGN_BIT];
        end
        default: ;
      endcase
    end
    if (onHit) begin
      softEn_nxt = 1'b1;
    end else if (xSlpHit) begin
      softEn_nxt = 1'b0;
    end
  end

  // Output selection: pin following, hardware override, then software enable.
  // Pin following ranks first, so hardware control cannot force a followed output low.
  always_comb begin
    if (onCode == sse_pkg::FOLLOW_EN1) begin
      extOut_nxt = pinSync[0];
    end else if (onCode == sse_pkg::FOLLOW_EN2) begin
      extOut_nxt = pinSync[1];
    end else if (hwcEn && hwcActive) begin
      extOut_nxt = 1'b0;
    end else begin
      extOut_nxt = softEn_r;
    end
  end

  // Regulator sleep handling; an ON walk restores it, ON voltage lives elsewhere.
  always_comb begin
    regEn_nxt  = regEn_r;
    regSlp_nxt = regSlp_r;
    if (walkStart) begin
      regEn_nxt  = 1'b1;
      regSlp_nxt = 1'b0;
    end else if (regTransHit) begin
      regSlp_nxt = 1'b1;
    end else if (regDisHit) begin
      if (hwAssign_r) begin
        regSlp_nxt = 1'b1;
      end else begin
        regEn_nxt = 1'b0;
      end
    end
    mv_nxt = sse_pkg::voltMv(reg11Cfg_r[sse_pkg::VSEL_MSB:sse_pkg::VSEL_LSB]);
  end

  // Read mux; unmapped addresses read zero.
  always_comb begin
    rdata_nxt = 16'h0000;
    if (rd) begin
      case (addr)
        sse_pkg::REG11_SLEEP_ADDR: rdata_nxt = reg11Cfg_r;
        sse_pkg::EXT_EN1_ADDR:     rdata_nxt = extCfg_r;
        sse_pkg::CTRL_ADDR:        rdata_nxt = {14'h0000, hwAssign_r, softEn_r};
        sse_pkg::STATUS_ADDR: rdata_nxt = {4'h0, pinSync, busy, sleepPhase, slot,
                                           extOut_r, regEn_r, regSlp_r};
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg11Cfg_r <= sse_pkg::REG11_RST;
      extCfg_r   <= sse_pkg::EXT_RST;
      softEn_r   <= 1'b0;
      hwAssign_r <= 1'b0;
      extOut_r   <= 1'b0;
      regEn_r    <= 1'b0;
      regSlp_r   <= 1'b0;
      mv_r       <= sse_pkg::VOLT_BASE_MV;
      rdata_r    <= 16'h0000;
    end else begin
      reg11Cfg_r <= reg11Cfg_nxt;
      extCfg_r   <= extCfg_nxt;
      softEn_r   <= softEn_nxt;
      hwAssign_r <= hwAssign_nxt;
      extOut_r   <= extOut_nxt;
      regEn_r    <= regEn_nxt;
      regSlp_r   <= regSlp_nxt;
      mv_r       <= mv_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  assign rdata        = rdata_r;
  assign extPowerEn1  = extOut_r;
  assign reg11Enable  = regEn_r;
  assign reg11Sleep   = regSlp_r;
  assign reg11SleepMv = mv_r;

  // Cycles since the last slot pulse; only the pace check reads it.
  logic [31:0] sinceSlot_r;
  logic [31:0] sinceSlot_nxt;

  always_comb begin
    sinceSlot_nxt = slotPulse ? 32'h0000_0000 : sinceSlot_r + 32'h0000_0001;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sinceSlot_r <= 32'h0000_0000;
    end else begin
      sinceSlot_r <= sinceSlot_nxt;
    end
  end

  // Checks on the decoded behaviour.
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  reg_trans_a: assert property (
    slotPulse && sleepPhase && !onStart && (sse_pkg::transSlot(regCode) == slot)
      |=> reg11Sleep && $stable(reg11Enable))
    else $error("Regulator sleep transition missed its slot.");

  reg_disable_a: assert property (
    regDisHit && !onStart && !hwAssign_r |=> !reg11Enable)
    else $error("Regulator not disabled in its sleep slot.");

  reg_hw_sleep_a: assert property (
    regDisHit && !onStart && hwAssign_r && reg11Enable |=> reg11Enable && reg11Sleep)
    else $error("Hardware-assigned regulator did not enter sleep.");

  sleep_volt_a: assert property (
    wr && (addr == sse_pkg::REG11_SLEEP_ADDR) ##1 !wr[*1]
      |=> reg11SleepMv == 11'(11'h320 + 11'($past(wdata[3:0], 2)) * 11'h032))
    else $error("Sleep millivolts do not match the code.");

  on_slot_a: assert property (
    onHit ##1 (onCode < 3'h6) && !(hwcEn && hwcActive) |=> extPowerEn1)
    else $error("Enable not asserted in its ON slot.");

  follow_pin_a: assert property (
    (onCode == 3'h6) |=> extPowerEn1 == $past(pinSync[0]))
    else $error("Enable does not follow hardware enable 1.");

  follow_pin2_a: assert property (
    (onCode == 3'h7) |=> extPowerEn1 == $past(pinSync[1]))
    else $error("Enable does not follow hardware enable 2.");

  soft_only_a: assert property (
    (onCode < 3'h6) && !hwcEn |=> extPowerEn1 == $past(softEn_r))
    else $error("Enable does not follow the software bit.");

  src_none_a: assert property (
    (onCode < 3'h6) && hwcEn && (hwSrc == 2'b00) |=> extPowerEn1 == $past(softEn_r))
    else $error("Disabled source still overrides the enable.");

  hw_force_a: assert property (
    (onCode < 3'h6) && hwcEn && hwcActive |=> !extPowerEn1)
    else $error("Active hardware control did not force the enable low.");

  sleep_clear_a: assert property (
    xSlpHit ##1 (onCode < 3'h6) |=> !extPowerEn1)
    else $error("Enable not deasserted in its sleep slot.");

  // Codes that call for no action must leave the state alone.
  on_none_a: assert property (
    slotPulse && !sleepPhase && (onCode == 3'h0) && !(wr && (addr == sse_pkg::CTRL_ADDR))
      |=> softEn_r == $past(softEn_r))
    else $error("ON slot code zero still changed the enable.");

  sleep_noop_a: assert property (
    slotPulse && sleepPhase && ((xSlpCode == 3'h0) || (xSlpCode >= 3'h6))
      && !(wr && (addr == sse_pkg::CTRL_ADDR)) |=> softEn_r == $past(softEn_r))
    else $error("Enable sleep slot acted on a no-action code.");

  reg_no_sleep_a: assert property (
    slotPulse && sleepPhase && (regCode != 3'h0) && (regCode <= 3'h5) && !hwAssign_r
      && !reg11Sleep |=> !reg11Sleep)
    else $error("Disable code put the regulator into sleep.");

  hw_ignore_a: assert property (
    (onCode < 3'h6) && !hwcEn && hwcActive |=> extPowerEn1 == $past(softEn_r))
    else $error("Hardware control acted while disabled.");

  slot_pace_a: assert property (
    slotPulse && (slot != 3'h1) |-> sinceSlot_r == 32'(SLOT_CYCLES - 1))
    else $error("Timeslot arrived off its interval.");

  on_walk_c: cover property (onHit ##[1:3] extPowerEn1);
  reg_off_c: cover property (regDisHit ##1 !reg11Enable);
  hw_force_c: cover property (hwcEn && hwcActive && softEn_r ##1 !extPowerEn1);
  follow_c: cover property ((onCode == 3'h6) && pinSync[0] ##1 extPowerEn1);
  sleep_trans_c: cover property (regTransHit ##1 reg11Sleep);
endmodule
`default_nettype wire

// ==== test/sse_pwr_host.sv ====
/*
  Model of the power state machine and the board pin drivers that stand
  around the sleep-slot block.
  Assumes the bench asks for a walk by raising a request for one cycle and
  sets the wanted pin levels itself.
*/
`timescale 1ns/100ps
`default_nettype none
module sse_pwr_host (
  input  wire logic       clk,        // System clock.
  input  wire logic       rst,        // Synchronous reset, active high.
  input  wire logic       reqOn,      // Bench asks for an ON walk.
  input  wire logic       reqSleep,   // Bench asks for a SLEEP walk.
  input  wire logic [3:0] pinLevel,   // Wanted levels: ctrl2, ctrl1, en2, en1.
  output logic            onStart,    // ON walk start pulse.
  output logic            sleepStart, // SLEEP walk start pulse.
  output logic            hwEnable1,  // Hardware enable pin 1.
  output logic            hwEnable2,  // Hardware enable pin 2.
  output logic            hwControl1, // Hardware control pin 1.
  output logic            hwControl2  // Hardware control pin 2.
);
  logic reqOnQ;
  logic reqSleepQ;

  // Starts fire only on a rising request, so a held request never restarts a walk.
  always_ff @(posedge clk) begin
    if (rst) begin
      reqOnQ <= 1'b0;
      reqSleepQ <= 1'b0;
      onStart <= 1'b0;
      sleepStart <= 1'b0;
    end else begin
      reqOnQ <= reqOn;
      reqSleepQ <= reqSleep;
      onStart <= reqOn & ~reqOnQ;
      sleepStart <= reqSleep & ~reqSleepQ;
    end
  end

  // Pins settle one cycle after the request, as a slow board level would.
  always_ff @(posedge clk) begin
    {hwControl2, hwControl1, hwEnable2, hwEnable1} <= pinLevel;
  end
endmodule
`default_nettype wire

// ==== test/sse_ctrl_tb.sv ====
/*
  Self-checking bench for the sleep-slot and external-enable block.
  Assumes the host model in sse_pwr_host.sv and a shortened slot interval.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp, msg) begin checkCount++; if ((got) !== (exp)) begin fails++; $display("wrong value at %0t: %s", $time, msg); end end
module sse_ctrl_tb;
  localparam int SC = 8; // Short slot interval keeps each walk near fifty cycles.
  logic        clk;
  logic        rst;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        reqOn;
  logic        reqSleep;
  logic [3:0]  pinLevel;
  logic        onStart;
  logic        sleepStart;
  logic        hwEnable1;
  logic        hwEnable2;
  logic        hwControl1;
  logic        hwControl2;
  logic        extPowerEn1;
  logic        reg11Enable;
  logic        reg11Sleep;
  logic [10:0] reg11SleepMv;
  logic [2:0]  trace [0:47]; // Per cycle of a walk: ext, enable, sleep.
  int          fails;
  int          checkCount;

  sse_ctrl #(.SLOT_CYCLES(SC)) u_sse_ctrl (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .onStart(onStart), .sleepStart(sleepStart),
    .hwEnable1(hwEnable1), .hwEnable2(hwEnable2), .hwControl1(hwControl1),
    .hwControl2(hwControl2), .extPowerEn1(extPowerEn1),
    .reg11Enable(reg11Enable), .reg11Sleep(reg11Sleep), .reg11SleepMv(reg11SleepMv)
  );

  sse_pwr_host u_sse_pwr_host (
    .clk(clk), .rst(rst), .reqOn(reqOn), .reqSleep(reqSleep), .pinLevel(pinLevel),
    .onStart(onStart), .sleepStart(sleepStart), .hwEnable1(hwEnable1),
    .hwEnable2(hwEnable2), .hwControl1(hwControl1), .hwControl2(hwControl2)
  );

  // Free-running 50 MHz clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic close_out;
    if (fails == 0 && checkCount > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data is looked at only in its one valid cycle, then must fall back to zero.
  task automatic reg_read(input logic [15:0] a, input logic [15:0] e, input string msg);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    `CHK(rdata, e, msg)
    @(negedge clk);
    `CHK(rdata, 16'h0000, "rdata held")
  endtask

  // Runs one walk through the host model and records the outputs each cycle.
  task automatic walk(input logic isSleep);
    @(posedge clk);
    if (isSleep) begin
      reqSleep <= 1'b1;
    end else begin
      reqOn <= 1'b1;
    end
    @(posedge clk);
    reqOn <= 1'b0;
    reqSleep <= 1'b0;
    @(posedge clk);
    for (int j = 0; j < 48; j++) begin
      @(negedge clk);
      trace[j] = {extPowerEn1, reg11Enable, reg11Sleep};
    end
  endtask

  // Checks one output in the first cycle of slot s and once its action has landed.
  task automatic slot_edge(input int b, input int s, input logic v0, input logic v1,
                           input string msg);
    `CHK(trace[(s - 1) * SC][b], v0, msg)
    `CHK(trace[(s - 1) * SC + 5][b], v1, msg)
  endtask

  task automatic reset_values;
    `CHK(extPowerEn1, 1'b0, "ext after reset")
    `CHK(reg11SleepMv, 11'h320, "mv after reset")
    reg_read(16'h4088, 16'h0000, "reg11 reset");
    reg_read(16'h4089, 16'h0000, "ext reset");
    reg_read(16'h4100, 16'h0000, "unmapped read");
    walk(1'b0);
    `CHK(trace[47][2], 1'b0, "on code zero")
  endtask

  // Only the documented fields hold bits; the rest read as zero.
  task automatic reg_access;
    reg_write(16'h4088, 16'hffff);
    reg_read(16'h4088, 16'he00f, "reg11 mask");
    reg_write(16'h4089, 16'hffff);
    reg_write(16'h4100, 16'hffff);
    reg_read(16'h4089, 16'hf9e0, "ext mask");
    reg_write(16'h4089, 16'h0000);
    for (int c = 0; c < 16; c++) begin
      reg_write(16'h4088, 16'(c));
      @(posedge clk); // The code lands one edge after the write, the millivolts one later.
      @(negedge clk);
      `CHK(reg11SleepMv, 11'(800 + 50 * c), "sleep mv")
    end
  endtask

  task automatic on_and_sleep_slots;
    for (int k = 1; k <= 5; k++) begin
      reg_write(16'h4089, {k[2:0], 5'h00, k[2:0], 5'h00});
      reg_write(16'h4088, {k[2:0], 13'h0000});
      walk(1'b0);
      slot_edge(2, k, 1'b0, 1'b1, "on slot");
      `CHK(trace[47][1], 1'b1, "reg on")
      walk(1'b1);
      slot_edge(2, 6 - k, 1'b1, 1'b0, "ext off slot");
      slot_edge(1, 6 - k, 1'b1, 1'b0, "reg off slot");
      `CHK(trace[47][0], 1'b0, "no sleep mode")
    end
  endtask

  task automatic transition_slots;
    logic [2:0] codes [3] = '{3'h0, 3'h6, 3'h7};
    int         slots [3] = '{5, 3, 1};
    for (int i = 0; i < 3; i++) begin
      reg_write(16'h4089, {3'h1, 5'h00, codes[i], 5'h00});
      reg_write(16'h4088, {codes[i], 13'h0000});
      walk(1'b0);
      walk(1'b1);
      slot_edge(0, slots[i], 1'b0, 1'b1, "sleep mode slot");
      `CHK(trace[47][1], 1'b1, "stays enabled")
      `CHK(trace[47][2], 1'b1, "ext no action")
    end
  endtask

  // With the regulator on a hardware enable, a disable code only puts it to sleep.
  task automatic hw_assigned;
    reg_write(sse_pkg::CTRL_ADDR, 16'h0002);
    reg_read(sse_pkg::CTRL_ADDR, 16'h0002, "ctrl readback");
    reg_write(16'h4088, 16'h6000);
    walk(1'b0);
    walk(1'b1);
    slot_edge(0, 3, 1'b0, 1'b1, "hw sleep slot");
    `CHK(trace[47][1], 1'b1, "hw stays on")
    reg_write(sse_pkg::CTRL_ADDR, 16'h0000);
  endtask

  task automatic hw_follow;
    for (int m = 0; m < 8; m++) begin
      reg_write(16'h4089, {2'b11, m[2], 13'h0000});
      pinLevel <= {2'b00, m[1:0]};
      repeat (6) @(posedge clk);
      @(negedge clk);
      `CHK(extPowerEn1, m[2] ? m[1] : m[0], "follow pin")
    end
  endtask

  // Every source, override and pin pattern, with the software enable held on.
  task automatic hw_control;
    logic hit;
    reg_write(sse_pkg::CTRL_ADDR, 16'h0001);
    for (int m = 0; m < 32; m++) begin
      reg_write(16'h4089, {3'h0, m[3:2], 2'b00, m[4], 8'h00});
      pinLevel <= {m[1:0], 2'b00};
      repeat (6) @(posedge clk);
      @(negedge clk);
      hit = m[4] & ((m[2] & m[0]) | (m[3] & m[1]));
      `CHK(extPowerEn1, ~hit, "hw control")
    end
    pinLevel <= 4'h0;
  endtask

  // Main sequence: inputs quiet at time zero, sixteen cycles of reset, then scenarios.
  initial begin
    fails = 0;
    checkCount = 0;
    rst = 1'b1;
    addr = 16'h0000;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    reqOn = 1'b0;
    reqSleep = 1'b0;
    pinLevel = 4'h0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    reset_values();
    reg_access();
    on_and_sleep_slots();
    transition_slots();
    hw_assigned();
    hw_follow();
    hw_control();
    close_out();
  end

  // The run needs about fourteen hundred cycles; about seven times that means a hang.
  initial begin
    #200000;
    fails++;
    close_out();
  end
endmodule
`default_nettype wire
